/* design/apd_power_down.sv */
// Automatic power-down unit with signal blocking and memory deselect
//
// Notes on behaviour
// - When enabled, a four-bit idle counter starts once the strobe stops.
// - Fifteen idle external clock periods raise powerdown_signal and enter power-down.
// - Strobe pulsing again returns the block to normal operation.
// - Chip-select low or reset high also leaves power-down.
// - In power-down, MCU address/data are blocked and all memories deselected.
// - Memories go to standby; logic and port blocks keep running.
// - Power-down: MCU and logic pins hold, address out holds its last value, peripherals tri-state.
// - Blocking the external clock from logic never stops the idle counter.
// - Chip-select high disables flash, SRAM, io space, not the logic.
// - Bit 3 of register a set turns turbo off; zero means full power.
// - MCU writes registers at runtime; blocking bits gate strobes to the logic array only.
// - Toggling unblocked logic inputs keep logic awake, not the memories.
// - Memories idle while inputs are static and wake on transitions.
// - External clock pin feeds macrocells and idle counter in clock mode.
// - Battery-on indicator asserts, when routed, while main supply is below standby supply.
// - Bit 1 of register a enables the auto power-down unit.
// - Bits 4 and 5 of register a cut the clock from array and macrocells.
// - Register b bits 2 to 5 cut WR, RD, PSEN, ALE from the array.
// - Registers clear only at power-up, not on later resets.
`timescale 1ns/1ns
`default_nettype none
`include "apd_defines.svh"
module apd_power_down
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8,
  parameter int PERI_W = 8
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  por,
  input  wire logic                  wr_a,
  input  wire logic                  wr_b,
  input  wire logic [`APD_REG_W-1:0] wdata,
  output logic      [`APD_REG_W-1:0] power_mgmt_reg_a,
  output logic      [`APD_REG_W-1:0] power_mgmt_reg_b,
  input  wire logic                  ext_logic_clock,
  input  wire logic                  ext_logic_clock_mode,
  input  wire logic                  chip_select_n,
  input  wire apd_pkg::apd_ctl_t     mcu_ctl,
  input  wire logic [ADDR_W-1:0]     mcu_addr,
  input  wire logic [DATA_W-1:0]     mcu_data,
  input  wire apd_pkg::apd_sel_t     mem_sel_req,
  input  wire logic [PERI_W-1:0]     peri_out,
  input  wire logic [PERI_W-1:0]     peri_oe_req,
  input  wire logic                  vcc_below_stby,
  input  wire logic                  battery_on_indicator_route,
  output logic                       powerdown_signal,
  output logic [ADDR_W-1:0]          mem_addr,
  output logic [DATA_W-1:0]          mem_data,
  output apd_pkg::apd_sel_t          mem_sel,
  output logic                       mem_standby,
  output apd_pkg::apd_ctl_t          array_ctl,
  output logic                       array_clk,
  output logic                       mcell_clk,
  output logic                       turbo_off,
  output logic                       logic_active,
  output logic [PERI_W-1:0]          peri_o,
  output logic [PERI_W-1:0]          peri_oe_n,
  output logic                       battery_on_indicator
);
  logic [`APD_REG_W-1:0] reg_a;
  logic [`APD_REG_W-1:0] reg_b;
  logic                  apd_en;

  apd_pwr_regs u_regs
  (
    .sys_clk (sys_clk),
    .por     (por),
    .wr_a    (wr_a),
    .wr_b    (wr_b),
    .wdata   (wdata),
    .reg_a   (reg_a),
    .reg_b   (reg_b)
  );

  assign power_mgmt_reg_a = reg_a;
  assign power_mgmt_reg_b = reg_b;
  assign apd_en = reg_a[`APD_A_ENABLE_BIT];

  // Edge history of strobe and external clock; both taken as synchronous
  logic ale_d_r;
  logic ale_d_nxt;
  logic clk_d_r;
  logic clk_d_nxt;
  logic ale_edge;
  logic clk_rise;

  always_comb
  begin
    ale_d_nxt = mcu_ctl.ale;
    clk_d_nxt = ext_logic_clock;
  end

  // Reset loads the live pins, so no false edge is seen after release
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ale_d_r <= ale_d_nxt;
      clk_d_r <= clk_d_nxt;
    end
    else
    begin
      ale_d_r <= ale_d_nxt;
      clk_d_r <= clk_d_nxt;
    end
  end

  assign ale_edge = mcu_ctl.ale ^ ale_d_r;
  // Counter clock ignores the blocking bits on purpose
  assign clk_rise = ext_logic_clock_mode & ext_logic_clock & ~clk_d_r;

  // Idle counter and power-down state
  logic [`APD_CNT_W-1:0] cnt_r;
  logic [`APD_CNT_W-1:0] cnt_nxt;
  apd_pkg::apd_state_t   st_r;
  apd_pkg::apd_state_t   st_nxt;
  logic                  wake;

  // Strobe edge or chip select low wakes; reset clears the state separately
  assign wake = ale_edge | ~chip_select_n;

  // Count saturates if chip select is low at the limit; strobe activity restarts it
  always_comb
  begin
    cnt_nxt = cnt_r;
    st_nxt  = st_r;
    if (!apd_en)
    begin
      cnt_nxt = '0;
      st_nxt  = apd_pkg::APD_RUN;
    end
    else
    begin
      unique case (st_r)
        apd_pkg::APD_RUN:
        begin
          if (ale_edge)
          begin
            cnt_nxt = '0;
          end
          else if (clk_rise)
          begin
            if (cnt_r == `APD_IDLE_LIMIT - 4'h1)
            begin
              cnt_nxt = `APD_IDLE_LIMIT;
              if (chip_select_n)
              begin
                st_nxt = apd_pkg::APD_DOWN;
              end
            end
            else if (cnt_r != `APD_IDLE_LIMIT)
            begin
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        apd_pkg::APD_DOWN:
        begin
          if (wake)
          begin
            st_nxt  = apd_pkg::APD_RUN;
            cnt_nxt = '0;
          end
        end
      endcase
    end
  end

  // Reset high forces normal operation and a fresh count
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cnt_r <= '0;
      st_r  <= apd_pkg::APD_RUN;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      st_r  <= st_nxt;
    end
  end

  logic down;
  assign down = (st_r == apd_pkg::APD_DOWN);

  // Memory-side bus: held frozen while down so memories see no transitions
  logic [ADDR_W-1:0]  maddr_r;
  logic [ADDR_W-1:0]  maddr_nxt;
  logic [DATA_W-1:0]  mdata_r;
  logic [DATA_W-1:0]  mdata_nxt;
  apd_pkg::apd_sel_t  msel_r;
  apd_pkg::apd_sel_t  msel_nxt;
  logic               mstb_r;
  logic               mstb_nxt;

  always_comb
  begin
    maddr_nxt = maddr_r;
    mdata_nxt = mdata_r;
    msel_nxt  = mem_sel_req;
    if (!down)
    begin
      maddr_nxt = mcu_addr;
      mdata_nxt = mcu_data;
    end
    if (down)
    begin
      msel_nxt = '0;
    end
    if (chip_select_n)
    begin
      // Flash, SRAM and io space off; logic untouched
      msel_nxt = '0;
    end
    // Standby when down, chip select high or no memory input moves; otherwise wakes on any change
    mstb_nxt = down | chip_select_n
             | ((mcu_addr == maddr_r) & (mcu_data == mdata_r)
                & (mem_sel_req == msel_r));
  end

  // Standby starts set, as no access is pending after reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      maddr_r <= '0;
      mdata_r <= '0;
      msel_r  <= '0;
      mstb_r  <= 1'b1;
    end
    else
    begin
      maddr_r <= maddr_nxt;
      mdata_r <= mdata_nxt;
      msel_r  <= msel_nxt;
      mstb_r  <= mstb_nxt;
    end
  end

  // Logic-array side: blocking bits gate each strobe and the clock
  logic act_r;
  logic act_nxt;
  apd_pkg::apd_ctl_t ctl_blk;
  // Gated strobes of the previous cycle; a change shows one cycle late
  apd_pkg::apd_ctl_t ctl_prev_r;
  apd_pkg::apd_ctl_t ctl_prev_nxt;

  always_comb
  begin
    ctl_blk.wr   = mcu_ctl.wr   & ~reg_b[`APD_B_WR_BIT];
    ctl_blk.rd   = mcu_ctl.rd   & ~reg_b[`APD_B_RD_BIT];
    ctl_blk.psen = mcu_ctl.psen & ~reg_b[`APD_B_PSEN_BIT];
    ctl_blk.ale  = mcu_ctl.ale  & ~reg_b[`APD_B_ALE_BIT];
    ctl_prev_nxt = ctl_blk;
    // Logic stays awake on any unblocked toggle, or always in turbo
    act_nxt = ~reg_a[`APD_A_TURBO_BIT]
            | ((ctl_blk != ctl_prev_r)
               | (clk_rise & ~reg_a[`APD_A_ARRCLK_BIT]));
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      act_r      <= 1'b1;
      ctl_prev_r <= '0;
    end
    else
    begin
      act_r      <= act_nxt;
      ctl_prev_r <= ctl_prev_nxt;
    end
  end

  // Logic keeps running in power-down; only the memory bus is frozen
  assign array_ctl    = ctl_blk;
  assign array_clk    = ext_logic_clock_mode & ext_logic_clock & ~reg_a[`APD_A_ARRCLK_BIT];
  assign mcell_clk    = ext_logic_clock_mode & ext_logic_clock & ~reg_a[`APD_A_MCCLK_BIT];
  assign turbo_off    = reg_a[`APD_A_TURBO_BIT];
  assign logic_active = act_r;

  // Peripheral pins float while down; enable is active low
  assign peri_o    = peri_out;
  assign peri_oe_n = down ? {PERI_W{1'b1}} : ~peri_oe_req;

  assign powerdown_signal     = down;
  assign mem_addr             = maddr_r;
  assign mem_data             = mdata_r;
  assign mem_sel              = msel_r;
  assign mem_standby          = mstb_r;
  assign battery_on_indicator = battery_on_indicator_route & vcc_below_stby;
endmodule
`default_nettype wire

/* design/apd_defines.svh */
// Constants for the automatic power-down control block
`ifndef APD_DEFINES_SVH
`define APD_DEFINES_SVH
`define APD_CNT_W          4
`define APD_IDLE_LIMIT     4'hf
`define APD_REG_W          8
`define APD_REG_RST        8'h00
`define APD_A_ENABLE_BIT   1
`define APD_A_TURBO_BIT    3
`define APD_A_ARRCLK_BIT   4
`define APD_A_MCCLK_BIT    5
`define APD_B_WR_BIT       2
`define APD_B_RD_BIT       3
`define APD_B_PSEN_BIT     4
`define APD_B_ALE_BIT      5
`define APD_A_USED_MASK    8'h3a
`define APD_B_USED_MASK    8'h3c
`endif

/* design/apd_pkg.sv */
// Types shared by the automatic power-down control block
`default_nettype none
package apd_pkg;
  // MCU control strobes towards the logic array
  typedef struct packed {
    logic wr;
    logic rd;
    logic psen;
    logic ale;
  } apd_ctl_t;

  // Memory select lines
  typedef struct packed {
    logic flash_main;
    logic flash_boot;
    logic sram;
    logic io_space;
  } apd_sel_t;

  typedef enum logic [0:0] {
    APD_RUN,
    APD_DOWN
  } apd_state_t;
endpackage
`default_nettype wire

/* design/apd_pwr_regs.sv */
// Power-management register pair, cleared at power-up only
`timescale 1ns/1ns
`default_nettype none
`include "apd_defines.svh"
module apd_pwr_regs
(
  input  wire logic                  sys_clk,
  input  wire logic                  por,
  input  wire logic                  wr_a,
  input  wire logic                  wr_b,
  input  wire logic [`APD_REG_W-1:0] wdata,
  output logic      [`APD_REG_W-1:0] reg_a,
  output logic      [`APD_REG_W-1:0] reg_b
);
  logic [`APD_REG_W-1:0] reg_a_r;
  logic [`APD_REG_W-1:0] reg_a_nxt;
  logic [`APD_REG_W-1:0] reg_b_r;
  logic [`APD_REG_W-1:0] reg_b_nxt;

  // Unused bits are forced to zero so reads stay clean
  always_comb
  begin
    reg_a_nxt = reg_a_r;
    reg_b_nxt = reg_b_r;
    if (wr_a)
    begin
      reg_a_nxt = wdata & `APD_A_USED_MASK;
    end
    if (wr_b)
    begin
      reg_b_nxt = wdata & `APD_B_USED_MASK;
    end
  end

  // Only power-on clears; sys_rst is deliberately not seen here
  always_ff @(posedge sys_clk)
  begin
    if (por)
    begin
      reg_a_r <= `APD_REG_RST;
      reg_b_r <= `APD_REG_RST;
    end
    else
    begin
      reg_a_r <= reg_a_nxt;
      reg_b_r <= reg_b_nxt;
    end
  end

  assign reg_a = reg_a_r;
  assign reg_b = reg_b_r;
endmodule
`default_nettype wire

/* testbench/apd_mcu_model.sv */
// Microcontroller bus model: address strobe, control strobes, address and data
`timescale 1ns/1ns
`default_nettype none
module apd_mcu_model
(
  input  wire logic          sys_clk,
  input  wire logic          run,
  output apd_pkg::apd_ctl_t  mcu_ctl,
  output logic [15:0]        mcu_addr,
  output logic [7:0]         mcu_data
);
  // Odd step toggles the strobe every cycle while running; asleep it stays put
  // Idle bus lines flip each cycle, as a released bus would not hold its value
  initial
  begin
    mcu_ctl  = '0;
    mcu_addr = 16'h1234;
    mcu_data = 8'h00;
    forever
    begin
      @(posedge sys_clk);
      if (run)
      begin
        mcu_ctl  <= mcu_ctl + 4'h3;
        mcu_addr <= mcu_addr + 16'h0101;
        mcu_data <= mcu_data + 8'h37;
      end
      else
      begin
        mcu_addr <= ~mcu_addr;
        mcu_data <= ~mcu_data;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/apd_power_down_assertions.sv */
// Checker for the automatic power-down block ports
`timescale 1ns/1ns
`default_nettype none
module apd_power_down_checker
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8,
  parameter int PERI_W = 8
)
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        power_mgmt_reg_a,
  input  wire logic [7:0]        power_mgmt_reg_b,
  input  wire logic              chip_select_n,
  input  wire apd_pkg::apd_ctl_t mcu_ctl,
  input  wire apd_pkg::apd_sel_t mem_sel,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [DATA_W-1:0] mem_data,
  input  wire logic              powerdown_signal,
  input  wire apd_pkg::apd_ctl_t array_ctl,
  input  wire logic              turbo_off,
  input  wire logic [PERI_W-1:0] peri_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Steps of the wake-up and the settled power-down state
  sequence s_down;
    powerdown_signal;
  endsequence
  sequence s_held_down;
    $past(powerdown_signal) && powerdown_signal;
  endsequence

  chk_wake_on_strobe: assert property (s_down ##0 $changed(mcu_ctl.ale) |=> !powerdown_signal)
    else $error("power-down kept after strobe activity");
  chk_wake_on_select: assert property (s_down ##0 !chip_select_n |=> !powerdown_signal)
    else $error("power-down kept with chip select low");
  chk_disabled_stays_low: assert property (!power_mgmt_reg_a[1] |=> !powerdown_signal)
    else $error("power-down raised while disabled");
  chk_down_deselect: assert property (s_held_down |-> mem_sel == '0)
    else $error("memory selected in power-down");
  chk_cs_deselect: assert property ($past(chip_select_n) |-> mem_sel == '0)
    else $error("memory selected with chip select high");
  chk_bus_frozen: assert property (s_held_down |-> $stable(mem_addr) && $stable(mem_data))
    else $error("memory bus moved in power-down");
  chk_peri_tristate: assert property (s_down |-> peri_oe_n == '1)
    else $error("peripheral pin driven in power-down");
  chk_array_blocking: assert property (array_ctl == (mcu_ctl & ~{power_mgmt_reg_b[2],
    power_mgmt_reg_b[3], power_mgmt_reg_b[4], power_mgmt_reg_b[5]}))
    else $error("control strobe blocking wrong");
  chk_turbo_bit: assert property (turbo_off == power_mgmt_reg_a[3])
    else $error("turbo output differs from its bit");
endmodule
`default_nettype wire

bind apd_power_down apd_power_down_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .PERI_W(PERI_W))
  apd_power_down_checker_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .power_mgmt_reg_a(power_mgmt_reg_a), .power_mgmt_reg_b(power_mgmt_reg_b),
  .chip_select_n(chip_select_n), .mcu_ctl(mcu_ctl), .mem_sel(mem_sel), .mem_addr(mem_addr),
  .mem_data(mem_data), .powerdown_signal(powerdown_signal), .array_ctl(array_ctl),
  .turbo_off(turbo_off), .peri_oe_n(peri_oe_n));

/* testbench/apd_power_down_tb.sv */
// Self-checking bench for the automatic power-down block
`timescale 1ns/1ns
`default_nettype none
`define APD_CHK(nm, ex, ac) begin n_compared++; if ((ac) !== (ex)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, ac); end end
module apd_power_down_tb;
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              por = 1'b1;
  logic              wr_a = 1'b0;
  logic              wr_b = 1'b0;
  logic [7:0]        wdata = 8'h00;
  logic              ext_logic_clock = 1'b0;
  logic              chip_select_n = 1'b1;
  logic              vcc_below_stby = 1'b0;
  logic              mcu_run = 1'b1;
  logic              ext_logic_clock_mode = 1'b1;
  logic              battery_on_indicator_route = 1'b1;
  logic              mem_standby, array_clk, mcell_clk, logic_active;
  logic [7:0]        peri_o, peri_oe_n;
  logic [7:0]        power_mgmt_reg_a, power_mgmt_reg_b;
  logic              powerdown_signal, turbo_off, battery_on_indicator;
  apd_pkg::apd_ctl_t mcu_ctl, array_ctl;
  apd_pkg::apd_sel_t mem_sel;
  logic [15:0]       mcu_addr;
  logic [7:0]        mcu_data;
  int                failures = 0, n_compared = 0, cyc = 0;

  always #20 sys_clk = ~sys_clk;

  apd_mcu_model apd_mcu_model_i (.sys_clk(sys_clk), .run(mcu_run), .mcu_ctl(mcu_ctl),
    .mcu_addr(mcu_addr), .mcu_data(mcu_data));

  apd_power_down apd_power_down_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .por(por),
    .wr_a(wr_a), .wr_b(wr_b), .wdata(wdata), .power_mgmt_reg_a(power_mgmt_reg_a),
    .power_mgmt_reg_b(power_mgmt_reg_b), .ext_logic_clock(ext_logic_clock),
    .ext_logic_clock_mode(ext_logic_clock_mode), .chip_select_n(chip_select_n), .mcu_ctl(mcu_ctl),
    .mcu_addr(mcu_addr), .mcu_data(mcu_data), .mem_sel_req(4'hf), .peri_out(8'ha5),
    .peri_oe_req(8'hff), .vcc_below_stby(vcc_below_stby), .battery_on_indicator_route(battery_on_indicator_route),
    .powerdown_signal(powerdown_signal), .mem_addr(), .mem_data(), .mem_sel(mem_sel),
    .mem_standby(mem_standby), .array_ctl(array_ctl), .array_clk(array_clk),
    .mcell_clk(mcell_clk), .turbo_off(turbo_off), .logic_active(logic_active),
    .peri_o(peri_o), .peri_oe_n(peri_oe_n),
    .battery_on_indicator(battery_on_indicator));

  task final_report();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      failures++;
      final_report();
    end
  end

  task wr_reg(input logic sel_b, input logic [7:0] v);
    @(posedge sys_clk);
    wr_a <= !sel_b;
    wr_b <= sel_b;
    wdata <= v;
    @(posedge sys_clk);
    wr_a <= 1'b0;
    wr_b <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task cycles(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // Slow external clock: two cycles high, two low, far under the turbo-off limit
  task pd_after(input int n, input logic exp);
    repeat (n)
    begin
      @(posedge sys_clk);
      ext_logic_clock <= 1'b1;
      repeat (2) @(posedge sys_clk);
      ext_logic_clock <= 1'b0;
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    `APD_CHK("powerdown_signal", exp, powerdown_signal)
  endtask

  task enter();
    pd_after(14, 1'b0);
    pd_after(1, 1'b1);
  endtask

  task t_regs();
    wr_reg(1'b0, 8'hff);
    `APD_CHK("power_mgmt_reg_a", 8'h3a, power_mgmt_reg_a)
    wr_reg(1'b1, 8'hff);
    `APD_CHK("power_mgmt_reg_b", 8'h3c, power_mgmt_reg_b)
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    cycles(1);
    `APD_CHK("power_mgmt_reg_a", 8'h3a, power_mgmt_reg_a)
    @(posedge sys_clk);
    por <= 1'b1;
    @(posedge sys_clk);
    por <= 1'b0;
    cycles(1);
    `APD_CHK("power_mgmt_reg_a", 8'h00, power_mgmt_reg_a)
    `APD_CHK("power_mgmt_reg_b", 8'h00, power_mgmt_reg_b)
  endtask

  task t_idle_modes();
    @(posedge sys_clk);
    mcu_run <= 1'b0;
    wr_reg(1'b0, 8'h08);
    `APD_CHK("turbo_off", 1'b1, turbo_off)
    `APD_CHK("logic_active", 1'b0, logic_active)
    `APD_CHK("mem_standby", 1'b1, mem_standby)
    @(posedge sys_clk);
    ext_logic_clock <= 1'b1;
    cycles(1);
    `APD_CHK("array_clk", 1'b1, array_clk)
    `APD_CHK("mcell_clk", 1'b1, mcell_clk)
    `APD_CHK("logic_active", 1'b1, logic_active)
    @(posedge sys_clk);
    ext_logic_clock_mode <= 1'b0;
    cycles(1);
    `APD_CHK("mcell_clk", 1'b0, mcell_clk)
    @(posedge sys_clk);
    ext_logic_clock_mode <= 1'b1;
    ext_logic_clock <= 1'b0;
    pd_after(16, 1'b0);
    @(posedge sys_clk);
    vcc_below_stby <= 1'b1;
    cycles(1);
    `APD_CHK("battery_on_indicator", 1'b1, battery_on_indicator)
    @(posedge sys_clk);
    battery_on_indicator_route <= 1'b0;
    cycles(1);
    `APD_CHK("battery_on_indicator", 1'b0, battery_on_indicator)
  endtask

  task t_block();
    logic [3:0] m;
    @(posedge sys_clk);
    mcu_run <= 1'b1;
    for (int i = 2; i <= 5; i++)
    begin
      wr_reg(1'b1, 8'h01 << i);
      m = 4'h8 >> (i - 2);
      `APD_CHK("array_ctl", mcu_ctl & ~m, array_ctl)
    end
    cycles(1);
    `APD_CHK("logic_active", 1'b1, logic_active)
  endtask

  task t_sleep();
    wr_reg(1'b1, 8'h3c);
    cycles(1);
    `APD_CHK("logic_active", 1'b0, logic_active)
    wr_reg(1'b0, 8'h32);
    @(posedge sys_clk);
    chip_select_n <= 1'b0;
    ext_logic_clock <= 1'b1;
    cycles(2);
    `APD_CHK("mem_sel", 4'hf, mem_sel)
    `APD_CHK("mem_standby", 1'b0, mem_standby)
    `APD_CHK("array_clk", 1'b0, array_clk)
    `APD_CHK("mcell_clk", 1'b0, mcell_clk)
    @(posedge sys_clk);
    chip_select_n <= 1'b1;
    ext_logic_clock <= 1'b0;
    mcu_run <= 1'b0;
    enter();
    `APD_CHK("mem_sel", 4'h0, mem_sel)
    `APD_CHK("mem_standby", 1'b1, mem_standby)
    `APD_CHK("peri_oe_n", 8'hff, peri_oe_n)
    `APD_CHK("peri_o", 8'ha5, peri_o)
    @(posedge sys_clk);
    mcu_run <= 1'b1;
    @(posedge sys_clk);
    mcu_run <= 1'b0;
    cycles(3);
    `APD_CHK("powerdown_signal", 1'b0, powerdown_signal)
    `APD_CHK("peri_oe_n", 8'h00, peri_oe_n)
    enter();
    @(posedge sys_clk);
    chip_select_n <= 1'b0;
    cycles(2);
    `APD_CHK("powerdown_signal", 1'b0, powerdown_signal)
    @(posedge sys_clk);
    chip_select_n <= 1'b1;
    enter();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    cycles(1);
    `APD_CHK("powerdown_signal", 1'b0, powerdown_signal)
    `APD_CHK("power_mgmt_reg_a", 8'h32, power_mgmt_reg_a)
  endtask

  initial
  begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    por <= 1'b0;
    t_regs();
    t_idle_modes();
    t_block();
    t_sleep();
    final_report();
  end
endmodule
`default_nettype wire
